/* File: design/gcsc_pkg.sv */
// Package for the gain/current serial controller (host side).
// Assumes an APB slave port at 10 MHz and a three-wire serial amplifier.
package gcsc_pkg;
    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] WORD_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int CTRL_TXON_BIT = 0;
    localparam int CTRL_PWRUP_BIT = 1;
    localparam int CTRL_GO_BIT = 2;
    localparam logic [1:0] CTRL_RST = 2'h0;
    // ----------------------------------------------------------------
    // Word layout
    // ----------------------------------------------------------------
    localparam int WORD_BITS = 8;
    localparam int CL_MSB = 7;
    localparam int CL_LSB = 6;
    localparam int GAIN_MSB = 5;
    localparam logic [5:0] GAIN_MIN = 6'h01;
    localparam logic [5:0] GAIN_MAX = 6'h3c;
    localparam logic [7:0] WORD_RST = 8'h00;
    localparam logic [1:0] CL_HIGHEST = 2'h3;
    localparam logic [1:0] CL_LOWEST = 2'h0;
    // ----------------------------------------------------------------
    // Timing: serial clock half period
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 10000000;
    localparam int HALF_NS = 400;
    localparam int HALF_CYC = (HALF_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam logic [7:0] HALF_CNT = 8'(HALF_CYC - 1);
    // ----------------------------------------------------------------
    // Sequencer states, Gray along the path except CLOSE back to IDLE
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        GCSC_IDLE = 3'h0,
        GCSC_OPEN = 3'h1,
        GCSC_LOW = 3'h3,
        GCSC_HIGH = 3'h2,
        GCSC_CLOSE = 3'h6
    } gcsc_state_t;
endpackage : gcsc_pkg

/* File: design/gcsc_tick.sv */
// Rate divider: one-cycle enable pulse every N+1 cycles while running.
// Assumes a single clock domain; restarts when run is low.
`timescale 1ns/100ps
module gcsc_tick (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [7:0] limit,
    output logic tick
);
    logic [7:0] cnt_q;
    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    assign tick = run && (cnt_q == limit);
    // Count up to limit then wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 8'h00;
        end else if (!run || tick) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule : gcsc_tick

/* File: design/gcsc_ctrl.sv */
// Host controller for the amplifier's three-wire gain/current port.
// Software writes an 8-bit word and a go bit over APB; the block then
// frames the word with the load strobe and shifts it out MSB first.
// Assumes the amplifier samples data on the serial clock's rising edge.
// Function
// - The word is 8 bits, MSB first, current in 7:6, gain in 5:0.
// - Valid gain codes are 01 to 3c, one dB per step.
// - Current level 11 is highest and 00 is lowest of four presets.
// - A load begins by the strobe falling, which opens the clock.
// - Burst transmit is held low while power-down changes.
// - At power-up transmit stays low until a word is committed.
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module gcsc_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic serial_clk,
    output logic serial_word_in,
    output logic word_load_strobe_n,
    output logic burst_transmit_on,
    output logic power_up
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    gcsc_pkg::gcsc_state_t st_q, st_d;
    logic [7:0] word_q;
    logic [7:0] shift_q;
    logic [2:0] bit_q;
    logic txon_req_q, pwr_req_q, committed_q, range_err_q;
    logic busy;
    logic tick;
    logic run;

    // ----------------------------------------------------------------
    // APB decode; zero wait states
    // ----------------------------------------------------------------
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire hit_ctrl = (paddr == gcsc_pkg::CTRL_OFS);
    wire hit_word = (paddr == gcsc_pkg::WORD_OFS);
    wire hit_stat = (paddr == gcsc_pkg::STAT_OFS);
    wire mapped = hit_ctrl || hit_word || hit_stat;
    wire go = wr && hit_ctrl && pwdata[gcsc_pkg::CTRL_GO_BIT] && !busy;
    // Word writes during a load are dropped to keep the frame coherent
    wire word_we = wr && hit_word && !busy;
    wire ctrl_we = wr && hit_ctrl;
    wire [5:0] gain = word_q[gcsc_pkg::GAIN_MSB:0];
    wire bad_gain = (gain < gcsc_pkg::GAIN_MIN) ||
                    (gain > gcsc_pkg::GAIN_MAX);
    wire [31:0] rd_mux =
        hit_ctrl ? {30'h0, pwr_req_q, txon_req_q} :
        hit_word ? {24'h0, word_q} :
        hit_stat ? {28'h0, range_err_q, committed_q, busy, 1'b0} :
        32'h0;
    // Power-down only moves while transmit is parked low
    wire pwr_change = (pwr_req_q != power_up);
    // Transmit also waits for the power pin, so it never runs powered down
    wire tx_allow = txon_req_q && committed_q && !pwr_change &&
                    power_up;
    assign busy = (st_q != gcsc_pkg::GCSC_IDLE);
    assign run = (st_q == gcsc_pkg::GCSC_LOW) ||
                 (st_q == gcsc_pkg::GCSC_HIGH) ||
                 (st_q == gcsc_pkg::GCSC_OPEN) ||
                 (st_q == gcsc_pkg::GCSC_CLOSE);
    // Next bit leaves as the clock falls, never as it rises
    wire shift_now = tick && ((st_q == gcsc_pkg::GCSC_OPEN) ||
                     (st_q == gcsc_pkg::GCSC_HIGH && bit_q != 3'h0));

    gcsc_tick u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .run(run),
        .limit(gcsc_pkg::HALF_CNT),
        .tick(tick)
    );

    // APB response registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // Software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_q <= gcsc_pkg::WORD_RST;
            txon_req_q <= 1'b0;
            pwr_req_q <= 1'b0;
        end else begin
            if (word_we && pready) begin
                word_q <= pwdata[7:0];
            end
            if (ctrl_we && pready) begin
                txon_req_q <= pwdata[gcsc_pkg::CTRL_TXON_BIT];
                pwr_req_q <= pwdata[gcsc_pkg::CTRL_PWRUP_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // Frame sequencer
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        case (st_q)
            gcsc_pkg::GCSC_IDLE: begin
                if (go && pready) st_d = gcsc_pkg::GCSC_OPEN;
            end
            gcsc_pkg::GCSC_OPEN: begin
                if (tick) st_d = gcsc_pkg::GCSC_LOW;
            end
            gcsc_pkg::GCSC_LOW: begin
                if (tick) st_d = gcsc_pkg::GCSC_HIGH;
            end
            gcsc_pkg::GCSC_HIGH: begin
                if (tick) begin
                    st_d = (bit_q == 3'h0) ? gcsc_pkg::GCSC_CLOSE :
                                             gcsc_pkg::GCSC_LOW;
                end
            end
            gcsc_pkg::GCSC_CLOSE: begin
                if (tick) st_d = gcsc_pkg::GCSC_IDLE;
            end
            default: st_d = gcsc_pkg::GCSC_IDLE;
        endcase
    end

    // Pin drivers; data changes on falling clock, stable at rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= gcsc_pkg::GCSC_IDLE;
            shift_q <= 8'h00;
            bit_q <= 3'h0;
            serial_clk <= 1'b0;
            serial_word_in <= 1'b0;
            word_load_strobe_n <= 1'b1;
            committed_q <= 1'b0;
            range_err_q <= 1'b0;
        end else begin
            st_q <= st_d;
            if (st_q == gcsc_pkg::GCSC_IDLE && go && pready) begin
                shift_q <= word_q;
                bit_q <= 3'h7;
                word_load_strobe_n <= 1'b0;
                range_err_q <= bad_gain;
            end
            if (shift_now) begin
                serial_word_in <= shift_q[7];
                shift_q <= {shift_q[6:0], 1'b0};
            end
            if (tick && st_q == gcsc_pkg::GCSC_LOW) begin
                serial_clk <= 1'b1;
            end
            if (tick && st_q == gcsc_pkg::GCSC_HIGH) begin
                serial_clk <= 1'b0;
                bit_q <= bit_q - 3'h1;
            end
            if (tick && st_q == gcsc_pkg::GCSC_CLOSE) begin
                word_load_strobe_n <= 1'b1;
                committed_q <= 1'b1;
            end
        end
    end

    // Enable pins; transmit drops first, power moves once it is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burst_transmit_on <= 1'b0;
            power_up <= 1'b0;
        end else begin
            burst_transmit_on <= tx_allow;
            if (pwr_change && !burst_transmit_on) begin
                power_up <= pwr_req_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_tx_needs_commit: assert property (@(posedge pclk) disable iff (!presetn)
        burst_transmit_on |-> committed_q)
        else $error("transmit enabled before a commit");
    a_pwr_tx_low: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(power_up) |-> !$past(burst_transmit_on))
        else $error("power pin moved with transmit high");
    a_clk_in_frame: assert property (@(posedge pclk) disable iff (!presetn)
        serial_clk |-> !word_load_strobe_n)
        else $error("serial clock outside frame");
    a_data_stable: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(serial_clk) |-> $stable(serial_word_in))
        else $error("data moved at rising clock");
    a_strobe_idle: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == gcsc_pkg::GCSC_IDLE) |-> word_load_strobe_n)
        else $error("strobe low while idle");
    a_commit_edge: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(word_load_strobe_n) |-> committed_q && !serial_clk)
        else $error("strobe rose without commit");
    a_clk_fall: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(serial_clk) |-> serial_clk[*4] ##1 !serial_clk)
        else $error("serial clock high time wrong");
    a_range_flag: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(word_load_strobe_n) |=> range_err_q == $past(bad_gain))
        else $error("range flag not captured");
    a_tx_power: assert property (@(posedge pclk) disable iff (!presetn)
        burst_transmit_on |-> power_up)
        else $error("transmit while powered down");
endmodule : gcsc_ctrl

/* File: bench/gcsc_amp_model.sv */
// Behavioural model of the amplifier's three-wire gain/current port.
// Assumes the controller drives clock, data, load strobe and both levels.
`timescale 1ns/100ps
module gcsc_amp_model (
    input wire logic serial_clk,
    input wire logic serial_word_in,
    input wire logic word_load_strobe_n,
    input wire logic burst_transmit_on,
    input wire logic power_up,
    output logic [7:0] core_word,
    output logic core_valid,
    output logic [1:0] amp_mode,
    output int commits,
    output int bits_seen,
    output int faults
);
    // ----------------------------------------------------------------
    // Master-slave shift register and core latch
    // ----------------------------------------------------------------
    logic [7:0] master;
    logic [7:0] slave;
    logic armed;
    int cnt;
    // Nothing committed at power-up, so the core word is meaningless
    initial begin
        core_valid = 1'b0;
        core_word = 8'h00;
        slave = 8'h00;
        armed = 1'b0;
        commits = 0;
        bits_seen = 0;
        faults = 0;
        cnt = 0;
    end
    // Capture on rise only while loading is open; stray edges count as faults
    always @(posedge serial_clk) begin
        if (word_load_strobe_n === 1'b0) begin
            master = {slave[6:0], serial_word_in};
            cnt++;
        end else begin
            faults++;
        end
    end
    // Slave takes the bit on the following fall
    always @(negedge serial_clk) begin
        if (word_load_strobe_n === 1'b0) begin
            slave = master;
        end
    end
    // Strobe fall opens the clock line; armed avoids a commit at time 0
    always @(negedge word_load_strobe_n) begin
        cnt = 0;
        armed = 1'b1;
    end
    always @(posedge word_load_strobe_n) begin
        if (armed) begin
            core_word = slave;
            core_valid = 1'b1;
            commits++;
            bits_seen = cnt;
            armed = 1'b0;
        end
    end
    // Sleep changes with transmit high make output transients
    always @(power_up) begin
        if (burst_transmit_on === 1'b1) begin
            faults++;
        end
    end
    // 0 shutdown, 1 between-burst, 2 transmitting
    assign amp_mode = (power_up !== 1'b1) ? 2'h0 :
        (burst_transmit_on !== 1'b1) ? 2'h1 : 2'h2;
endmodule : gcsc_amp_model

/* File: bench/testbench.sv */
// Self-checking bench for the gain/current serial controller.
// Assumes APB at 10 MHz and the amplifier model on the serial side.
`timescale 1ns/100ps
module testbench;
    logic pclk, presetn, psel, penable, pwrite, err, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic serial_clk, serial_word_in, word_load_strobe_n;
    logic burst_transmit_on, power_up, core_valid;
    logic [7:0] core_word;
    logic [1:0] amp_mode;
    int commits, bits_seen, faults, failures, tests_run, n;
    logic [7:0] words[$];
    gcsc_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_clk(serial_clk),
        .serial_word_in(serial_word_in),
        .word_load_strobe_n(word_load_strobe_n),
        .burst_transmit_on(burst_transmit_on), .power_up(power_up));
    gcsc_amp_model amp_u (.serial_clk(serial_clk),
        .serial_word_in(serial_word_in),
        .word_load_strobe_n(word_load_strobe_n),
        .burst_transmit_on(burst_transmit_on), .power_up(power_up),
        .core_word(core_word), .core_valid(core_valid),
        .amp_mode(amp_mode), .commits(commits), .bits_seen(bits_seen),
        .faults(faults));
    // ----------------------------------------------------------------
    // Clock, shared tasks and closing
    // ----------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check
    // One APB transfer; the idle edge at the end keeps strobes apart
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the watchdog ends a wait for the slave's answer
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop
    // Hang guard, far beyond the thousand or so cycles the run needs
    initial begin
        #5000000;
        failures++;
        report_and_stop();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, failures, tests_run} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        void'($urandom(32'h67880667));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check("strobe idle", 1, word_load_strobe_n);
        apb(1'b0, gcsc_pkg::STAT_OFS, 32'h0);
        check("stat reset", 0, rd);
        // Ask for transmit before any word: only power may follow
        apb(1'b1, gcsc_pkg::CTRL_OFS, 32'h3);
        repeat (4) @(posedge pclk);
        check("power up", 1, power_up);
        check("early transmit", 0, burst_transmit_on);
        $display("reset test done");
        // Every current level, gain edges and out-of-range codes
        words = '{8'hc1, 8'hbc, 8'h7c, 8'h01, 8'h00, 8'h3d, 8'hff};
        repeat (4) words.push_back(8'($urandom));
        foreach (words[i]) begin
            apb(1'b1, gcsc_pkg::WORD_OFS, {24'h0, words[i]});
            apb(1'b1, gcsc_pkg::CTRL_OFS, 32'h7);
            apb(1'b1, gcsc_pkg::WORD_OFS, {24'h0, ~words[i]});
            n = 0;
            do begin
                apb(1'b0, gcsc_pkg::STAT_OFS, 32'h0);
                n++;
            end while (rd[1] !== 1'b0 && n < 60);
            check("commits", i + 1, commits);
            check("core word", words[i], core_word);
            check("bit count", 8, bits_seen);
            check("committed", 1, rd[2]);
            check("range flag", words[i][5:0] == 6'h00 ||
                words[i][5:0] > gcsc_pkg::GAIN_MAX, rd[3]);
            check("transmit", 2, amp_mode);
        end
        $display("word test done");
        // Power down with transmit on: transmit must drop first
        apb(1'b1, gcsc_pkg::CTRL_OFS, 32'h0);
        n = 0;
        while (power_up !== 1'b0 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        check("shutdown", 0, amp_mode);
        apb(1'b1, gcsc_pkg::CTRL_OFS, 32'h2);
        repeat (8) @(posedge pclk);
        check("between burst", 1, amp_mode);
        check("transients", 0, faults);
        $display("power test done");
        apb(1'b0, 8'h0c, 32'h0);
        check("unmapped err", 1, err);
        $display("bus test done");
        report_and_stop();
    end
endmodule : testbench
